/* File: core/pattern_engine.sv */
// Pattern engine: stored byte pattern, width converter and two resistor counters.
// Assumes step, reloads and count clocks are synchronous levels; rising edges are detected here.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
module pattern_engine
    import pattern_engine_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        pattern_reset_n,
    input  wire logic        step,
    input  wire logic        resistor0_reload,
    input  wire logic        resistor1_reload,
    input  wire logic        resistor0_count_clock,
    input  wire logic        resistor1_count_clock,
    input  wire logic        resistor0_up,
    input  wire logic        resistor1_up,
    input  wire logic        i2c_stop,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    output logic      [7:0]  pattern_out,
    output logic      [9:0]  resistor0_count,
    output logic      [9:0]  resistor1_count
);

    engine_state_type state_r;
    conv_mode_type    conversion_mode_select_r;
    logic             pointer_wrap_select_r;
    logic             resistor_data_mapping_r;
    logic             pattern_to_resistor0_enable_r;
    logic             pattern_to_resistor1_enable_r;
    logic [7:0]       pattern_initial_value_r;
    logic [7:0]       pattern_mem_r [PATTERN_BYTES];
    logic [7:0]       ptr_r;
    logic [7:0]       ptr_nxt;
    logic [2:0]       sub_r;
    logic [7:0]       cur_byte_r;
    logic [9:0]       resistor0_setting_r;
    logic [9:0]       resistor1_setting_r;
    logic             pend0_r;
    logic             pend1_r;
    logic             step_d_r;
    logic             reload0_d_r;
    logic             reload1_d_r;
    logic             tick0_d_r;
    logic             tick1_d_r;
    logic             step_rise;
    logic             reload0_rise;
    logic             reload1_rise;
    logic             tick0_rise;
    logic             tick1_rise;
    logic             last_word;
    logic [15:0]      read_mux;

    // Offset of an address inside the pattern region
    function automatic logic [5:0] pattern_index(input logic [7:0] a);
        logic [7:0] d;
        d             = a - PATTERN_FIRST;
        pattern_index = d[5:0];
    endfunction

    function automatic logic in_pattern(input logic [7:0] a);
        in_pattern = (a >= PATTERN_FIRST) && (a <= PATTERN_LAST);
    endfunction

    // Priority: bus stop load, then pattern reload, then saturating count
    function automatic logic [9:0] count_next(input logic [9:0] cnt, input logic load_set, input logic [9:0] set,
                                              input logic reload, input logic [9:0] mapped, input logic tick,
                                              input logic up);
        if (load_set)
            count_next = set;
        else if (reload)
            count_next = mapped;
        else if (tick && up && cnt != COUNT_MAX)
            count_next = cnt + 10'h001;
        else if (tick && !up && cnt != COUNT_MIN)
            count_next = cnt - 10'h001;
        else
            count_next = cnt;
    endfunction

    // Edge detectors on the matrix-side levels
    always_ff @(posedge clock) begin
        if (reset) begin
            step_d_r    <= 1'h0;
            reload0_d_r <= 1'h0;
            reload1_d_r <= 1'h0;
            tick0_d_r   <= 1'h0;
            tick1_d_r   <= 1'h0;
        end else begin
            step_d_r    <= step;
            reload0_d_r <= resistor0_reload;
            reload1_d_r <= resistor1_reload;
            tick0_d_r   <= resistor0_count_clock;
            tick1_d_r   <= resistor1_count_clock;
        end
    end

    assign step_rise    = step & ~step_d_r;
    assign reload0_rise = resistor0_reload & ~reload0_d_r;
    assign reload1_rise = resistor1_reload & ~reload1_d_r;
    assign tick0_rise   = resistor0_count_clock & ~tick0_d_r;
    assign tick1_rise   = resistor1_count_clock & ~tick1_d_r;

    // A mode change mid-byte can leave sub_r past the end, so compare with >=
    assign last_word = sub_r >= last_index(conversion_mode_select_r);
    assign ptr_nxt   = (ptr_r == PATTERN_LAST) ? PATTERN_FIRST : ptr_r + 8'h01;

    // Software-written configuration and pattern storage
    always_ff @(posedge clock) begin
        if (reset) begin
            conversion_mode_select_r      <= MODE_PARALLEL;
            pointer_wrap_select_r         <= 1'h0;
            resistor_data_mapping_r       <= 1'h0;
            pattern_to_resistor0_enable_r <= 1'h0;
            pattern_to_resistor1_enable_r <= 1'h0;
            pattern_initial_value_r       <= INIT_VALUE_RESET;
            for (int i = 0; i < PATTERN_BYTES; i++) begin
                pattern_mem_r[i] <= PATTERN_RESET;
            end
        end else if (reg_write) begin
            if (reg_addr == ADDR_CONFIG) begin
                conversion_mode_select_r      <= conv_mode_type'(reg_wdata[CFG_MODE_LSB +: 2]);
                pointer_wrap_select_r         <= reg_wdata[CFG_WRAP_BIT];
                resistor_data_mapping_r       <= reg_wdata[CFG_MAP_BIT];
                pattern_to_resistor0_enable_r <= reg_wdata[CFG_EN0_BIT];
                pattern_to_resistor1_enable_r <= reg_wdata[CFG_EN1_BIT];
            end
            if (reg_addr == ADDR_INIT_VALUE)
                pattern_initial_value_r <= reg_wdata[7:0];
            if (in_pattern(reg_addr))
                pattern_mem_r[pattern_index(reg_addr)] <= reg_wdata[7:0];
        end
    end

    // Resistor settings; the counter only sees them at the bus stop
    always_ff @(posedge clock) begin
        if (reset) begin
            resistor0_setting_r <= RES0_SET_RESET;
            resistor1_setting_r <= RES1_SET_RESET;
        end else if (reg_write) begin
            if (reg_addr == ADDR_RES0_SET)
                resistor0_setting_r <= reg_wdata[9:0];
            if (reg_addr == ADDR_RES1_SET)
                resistor1_setting_r <= reg_wdata[9:0];
        end
    end

    // Pending flags: a write in the stop cycle stays pending for the next stop
    always_ff @(posedge clock) begin
        if (reset) begin
            pend0_r <= 1'h0;
            pend1_r <= 1'h0;
        end else begin
            pend0_r <= (reg_write && reg_addr == ADDR_RES0_SET) ? 1'h1 : (i2c_stop ? 1'h0 : pend0_r);
            pend1_r <= (reg_write && reg_addr == ADDR_RES1_SET) ? 1'h1 : (i2c_stop ? 1'h0 : pend1_r);
        end
    end

    // Generator: pointer, sub-word index and output word
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r     <= ST_INITIAL;
            ptr_r       <= PATTERN_FIRST;
            sub_r       <= 3'h0;
            cur_byte_r  <= PATTERN_RESET;
            pattern_out <= INIT_VALUE_RESET;
        end else if (!pattern_reset_n) begin
            state_r     <= ST_INITIAL;
            ptr_r       <= PATTERN_FIRST;
            sub_r       <= 3'h0;
            pattern_out <= pattern_initial_value_r;
        end else if (step_rise) begin
            case (state_r)
                ST_INITIAL: begin
                    // First step after reset shows the first stored byte, no advance
                    state_r     <= ST_RUN;
                    sub_r       <= 3'h0;
                    cur_byte_r  <= pattern_mem_r[pattern_index(ptr_r)];
                    pattern_out <= word_of(pattern_mem_r[pattern_index(ptr_r)], conversion_mode_select_r, 3'h0);
                end
                ST_RUN, ST_HALT: begin
                    if (!last_word) begin
                        sub_r       <= sub_r + 3'h1;
                        pattern_out <= word_of(cur_byte_r, conversion_mode_select_r, sub_r + 3'h1);
                    end else if (ptr_r == PATTERN_LAST && pointer_wrap_select_r) begin
                        // Halted: keep presenting the last byte
                        state_r     <= ST_HALT;
                        sub_r       <= 3'h0;
                        cur_byte_r  <= pattern_mem_r[pattern_index(ptr_r)];
                        pattern_out <= word_of(pattern_mem_r[pattern_index(ptr_r)], conversion_mode_select_r, 3'h0);
                    end else begin
                        state_r     <= ST_RUN;
                        ptr_r       <= ptr_nxt;
                        sub_r       <= 3'h0;
                        cur_byte_r  <= pattern_mem_r[pattern_index(ptr_nxt)];
                        pattern_out <= word_of(pattern_mem_r[pattern_index(ptr_nxt)], conversion_mode_select_r, 3'h0);
                    end
                end
                default: state_r <= ST_INITIAL;
            endcase
        end
    end

    // Resistor counters
    always_ff @(posedge clock) begin
        if (reset) begin
            resistor0_count <= RES0_SET_RESET;
            resistor1_count <= RES1_SET_RESET;
        end else begin
            resistor0_count <= count_next(resistor0_count, i2c_stop && pend0_r, resistor0_setting_r,
                                          reload0_rise && pattern_to_resistor0_enable_r,
                                          map_byte(pattern_out, resistor_data_mapping_r), tick0_rise, resistor0_up);
            resistor1_count <= count_next(resistor1_count, i2c_stop && pend1_r, resistor1_setting_r,
                                          reload1_rise && pattern_to_resistor1_enable_r,
                                          map_byte(pattern_out, resistor_data_mapping_r), tick1_rise, resistor1_up);
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        read_mux = 16'h0000;
        case (reg_addr)
            ADDR_CONFIG:     read_mux = {10'h000, pattern_to_resistor1_enable_r, pattern_to_resistor0_enable_r,
                                         resistor_data_mapping_r, pointer_wrap_select_r, conversion_mode_select_r};
            ADDR_POINTER:    read_mux = {5'h00, sub_r, ptr_r};
            ADDR_OUTPUT:     read_mux = {6'h00, state_r, pattern_out};
            ADDR_RES0_SET:   read_mux = {6'h00, resistor0_setting_r};
            ADDR_RES1_SET:   read_mux = {6'h00, resistor1_setting_r};
            ADDR_RES0_COUNT: read_mux = {6'h00, resistor0_count};
            ADDR_RES1_COUNT: read_mux = {6'h00, resistor1_count};
            ADDR_INIT_VALUE: read_mux = {8'h00, pattern_initial_value_r};
            default: begin
                if (in_pattern(reg_addr))
                    read_mux = {8'h00, pattern_mem_r[pattern_index(reg_addr)]};
            end
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= reg_read ? read_mux : 16'h0000;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence fetch_s;
        pattern_reset_n && step_rise && state_r != ST_INITIAL && last_word;
    endsequence

    sequence tick0_alone_s;
        !i2c_stop && !(reload0_rise && pattern_to_resistor0_enable_r) && tick0_rise;
    endsequence

    // Starts on the first edge out of reset; an attempt begun with reset high would be disabled
    power_up_init_a: assert property ($fell(reset) |-> pattern_out == INIT_VALUE_RESET && ptr_r == PATTERN_FIRST
                                      && resistor0_count == RES0_SET_RESET)
        else $error("outputs not at initial values after reset");

    matrix_reset_load_a: assert property (!pattern_reset_n |=> pattern_out == $past(pattern_initial_value_r)
                                          && ptr_r == PATTERN_FIRST)
        else $error("matrix reset did not rewind and load initial value");

    pointer_range_a: assert property (ptr_r >= PATTERN_FIRST && ptr_r <= PATTERN_LAST)
        else $error("pointer left the pattern region");

    pointer_wrap_a: assert property (fetch_s ##0 (ptr_r == PATTERN_LAST && !pointer_wrap_select_r)
                                     |=> ptr_r == PATTERN_FIRST && state_r == ST_RUN)
        else $error("pointer did not wrap to start");

    pointer_halt_a: assert property (fetch_s ##0 (ptr_r == PATTERN_LAST && pointer_wrap_select_r)
                                     |=> ptr_r == PATTERN_LAST && state_r == ST_HALT)
        else $error("pointer did not halt on last byte");

    fetch_advance_a: assert property (fetch_s ##0 (ptr_r != PATTERN_LAST)
                                      |=> ptr_r == $past(ptr_r) + 8'h01 && sub_r == 3'h0)
        else $error("fetch did not advance pointer by one");

    sub_word_hold_a: assert property (pattern_reset_n && step_rise && state_r != ST_INITIAL && !last_word
                                      |=> ptr_r == $past(ptr_r))
        else $error("pointer moved before last sub-word");

    word_order_a: assert property (pattern_reset_n && step_rise && state_r != ST_INITIAL
                                   |=> pattern_out == word_of(cur_byte_r, $past(conversion_mode_select_r), sub_r))
        else $error("output word does not match byte and mode");

    reload_map_a: assert property (!i2c_stop && reload0_rise && pattern_to_resistor0_enable_r
                                   |=> resistor0_count == ($past(resistor_data_mapping_r) ? {2'h0, $past(pattern_out)}
                                                                                      : {$past(pattern_out), 2'h0}))
        else $error("reload did not capture mapped pattern data");

    path_disabled_a: assert property (!i2c_stop && !tick1_rise && reload1_rise && !pattern_to_resistor1_enable_r
                                      |=> $stable(resistor1_count))
        else $error("disabled path changed counter");

    count_up_a: assert property (tick0_alone_s ##0 (resistor0_up && resistor0_count != COUNT_MAX)
                                 |=> resistor0_count == $past(resistor0_count) + 10'h001)
        else $error("counter did not count up");

    stop_load_a: assert property (reg_write && reg_addr == ADDR_RES0_SET && !i2c_stop ##1 !i2c_stop [*2] ##1 i2c_stop
                                  |=> resistor0_count == $past(resistor0_setting_r))
        else $error("setting not applied at bus stop");

endmodule // pattern_engine

/* File: core/pattern_engine_pkg.sv */
// Constants, types and helper functions shared by the pattern engine core.
// Assumes one 250 MHz clock; matrix signals arrive synchronous to it.
// How it works
// - Fetch bytes sequentially from the pattern region
// - Power-up and reset show the initial value
// - Wrap select low: pointer returns to start
// - Wrap select high: pointer halts on last byte
// - Low matrix reset rewinds pointer, loads initial
// - Mode field picks one of four widths
// - Parallel mode drives whole byte
// - Nibble mode emits two 4-bit words
// - Pair mode emits four 2-bit words
// - Serial mode shifts byte out bitwise
// - Each resistor path has its own enable
// - Enabled counter captures data on reload rise
// - Map low: data in bits 9..2
// - Map high: data in bits 7..0
// - Counters still count on their count clock
// - Power-on loads settings and counters from defaults
// - Setting write overwrites counter despite enabled path
// - Setting reaches counter only at bus stop
// - Configurable initial value used at matrix reset; power-up reset loads INIT_VALUE_RESET
package pattern_engine_pkg;

    // Register map of the software port
    localparam logic [7:0] ADDR_CONFIG      = 8'h00;
    localparam logic [7:0] ADDR_POINTER     = 8'h01;
    localparam logic [7:0] ADDR_OUTPUT      = 8'h02;
    localparam logic [7:0] ADDR_RES0_SET    = 8'h03;
    localparam logic [7:0] ADDR_RES1_SET    = 8'h04;
    localparam logic [7:0] ADDR_RES0_COUNT  = 8'h05;
    localparam logic [7:0] ADDR_RES1_COUNT  = 8'h06;
    localparam logic [7:0] ADDR_INIT_VALUE  = 8'hba;
    localparam logic [7:0] PATTERN_FIRST    = 8'hc2;
    localparam logic [7:0] PATTERN_LAST     = 8'hfc;
    localparam int         PATTERN_BYTES    = 59;

    // Configuration register fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_WRAP_BIT = 2;
    localparam int CFG_MAP_BIT  = 3;
    localparam int CFG_EN0_BIT  = 4;
    localparam int CFG_EN1_BIT  = 5;

    // Reset values and counter limits
    localparam logic [7:0]  INIT_VALUE_RESET = 8'h00;
    localparam logic [7:0]  PATTERN_RESET    = 8'h00;
    localparam logic [9:0]  RES0_SET_RESET   = 10'h200;
    localparam logic [9:0]  RES1_SET_RESET   = 10'h200;
    localparam logic [9:0]  COUNT_MAX        = 10'h3ff;
    localparam logic [9:0]  COUNT_MIN        = 10'h000;

    typedef enum logic [1:0] {
        MODE_PARALLEL = 2'h0,
        MODE_NIBBLE   = 2'h1,
        MODE_PAIR     = 2'h2,
        MODE_SERIAL   = 2'h3
    } conv_mode_type;

    // Gray path: initial -> run -> halt
    typedef enum logic [1:0] {
        ST_INITIAL = 2'h0,
        ST_RUN     = 2'h1,
        ST_HALT    = 2'h3
    } engine_state_type;

    // Index of the final sub-word of a byte in each mode
    function automatic logic [2:0] last_index(input conv_mode_type m);
        case (m)
            MODE_PARALLEL: last_index = 3'h0;
            MODE_NIBBLE:   last_index = 3'h1;
            MODE_PAIR:     last_index = 3'h3;
            MODE_SERIAL:   last_index = 3'h7;
            default:       last_index = 3'h0;
        endcase
    endfunction

    // Sub-word idx of byte b, most significant end first, zero extended
    function automatic logic [7:0] word_of(input logic [7:0] b, input conv_mode_type m, input logic [2:0] idx);
        logic [7:0] sh;
        sh = 8'h00;
        case (m)
            MODE_PARALLEL: word_of = b;
            MODE_NIBBLE:   word_of = {4'h0, (idx[0] ? b[3:0] : b[7:4])};
            MODE_PAIR: begin
                sh      = b << {idx[1:0], 1'h0};
                word_of = {6'h0, sh[7:6]};
            end
            MODE_SERIAL: begin
                sh      = b << idx;
                word_of = {7'h0, sh[7]};
            end
            default:       word_of = b;
        endcase
    endfunction

    // Place a pattern byte into a 10-bit counter word
    function automatic logic [9:0] map_byte(input logic [7:0] b, input logic from_lsb);
        map_byte = from_lsb ? {2'h0, b} : {b, 2'h0};
    endfunction

endpackage

/* File: testbench/matrix_model.sv */
// Routing matrix side of the pattern engine: generator clock, generator reset, reloads and count clocks.
// Assumes the bench calls its tasks; every change lands just after a rising clock edge.
module matrix_model (
    input  wire logic       clock,
    output logic            step,
    output logic            pattern_reset_n,
    output logic [1:0]      reload,
    output logic [1:0]      count_clock,
    output logic [1:0]      up
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] pins;

    // Pin 0 steps the generator, 1..2 reload, 3..4 count
    assign step        = pins[0];
    assign reload      = pins[2:1];
    assign count_clock = pins[4:3];

    initial begin
        pins            = 5'h00;
        up              = 2'h0;
        pattern_reset_n = 1'b1;
    end

    // One rising edge, then low; a generator step period of at least 250 cycles keeps
    // the step clock at or below 1 MHz, the tightest limit of all four modes
    task automatic strobe(input int sel, input logic dir);
        @(posedge clock);
        pins[sel] <= 1'b1;
        up        <= {dir, dir};
        @(posedge clock);
        pins[sel] <= 1'b0;
        repeat ((sel == 0) ? 249 : 1) @(posedge clock);
    endtask

    // Generator reset held low over two edges
    task automatic pattern_reset();
        @(posedge clock);
        pattern_reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        pattern_reset_n <= 1'b1;
        @(posedge clock);
    endtask
endmodule // matrix_model

/* File: testbench/tb.sv */
// Self-checking bench for the pattern engine; register port driven here, matrix side by matrix_model.
// Assumes one 250 MHz clock and the register map of the core package.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pattern_engine_pkg::*;

    logic        clock;
    logic        reset;
    logic        i2c_stop;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [7:0]  pattern_out;
    logic [9:0]  count0;
    logic [9:0]  count1;
    logic        step;
    logic        pattern_reset_n;
    logic [1:0]  reload;
    logic [1:0]  count_clock;
    logic [1:0]  up;
    logic [15:0] d;
    int          miscompares;
    int          tests_run;

    matrix_model mx (.clock(clock), .step(step), .pattern_reset_n(pattern_reset_n), .reload(reload),
                     .count_clock(count_clock), .up(up));

    pattern_engine dut (.clock(clock), .reset(reset), .pattern_reset_n(pattern_reset_n), .step(step),
        .resistor0_reload(reload[0]), .resistor1_reload(reload[1]), .resistor0_count_clock(count_clock[0]),
        .resistor1_count_clock(count_clock[1]), .resistor0_up(up[0]), .resistor1_up(up[1]),
        .i2c_stop(i2c_stop), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .pattern_out(pattern_out),
        .resistor0_count(count0), .resistor1_count(count1));

    // Free-running clock, 4 ns period
    initial clock = 1'b0;
    always #2 clock = ~clock;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic test_reset_values();
        rd(ADDR_CONFIG);
        check("config", d, 16'h0000);
        rd(ADDR_RES0_SET);
        check("setting0", d, 16'h0200);
        check("count1", {6'h00, count1}, 16'h0200);
        check("out", {8'h00, pattern_out}, 16'h0000);
    endtask

    task automatic test_initial_value();
        wr(8'hc2, 16'h00a5);
        wr(8'hc3, 16'h003c);
        wr(8'hfc, 16'h0077);
        wr(ADDR_INIT_VALUE, 16'h005a);
        mx.pattern_reset();
        #1 check("init out", {8'h00, pattern_out}, 16'h005a);
        rd(ADDR_POINTER);
        check("pointer", {8'h00, d[7:0]}, 16'h00c2);
    endtask

    // Every mode: words of 0xa5 most significant first, then word 0 of the next byte
    task automatic test_modes();
        int w;
        for (int m = 0; m < 4; m++) begin
            w = 8 >> m;
            wr(ADDR_CONFIG, 16'(m));
            mx.pattern_reset();
            for (int i = 0; i < (1 << m); i++) begin
                mx.strobe(0, 1'b0);
                #1 check("word", {8'h00, pattern_out}, 16'((8'ha5 >> (8 - w * (i + 1))) & ((1 << w) - 1)));
            end
            mx.strobe(0, 1'b0);
            #1 check("next byte", {8'h00, pattern_out}, 16'((8'h3c >> (8 - w)) & ((1 << w) - 1)));
        end
    endtask

    // Walk past the last byte with wrap select low or high
    task automatic test_wrap(input logic halt);
        wr(ADDR_CONFIG, halt ? 16'h0004 : 16'h0000);
        mx.pattern_reset();
        repeat (59) mx.strobe(0, 1'b0);
        rd(ADDR_POINTER);
        check("last ptr", {8'h00, d[7:0]}, 16'h00fc);
        mx.strobe(0, 1'b0);
        rd(ADDR_POINTER);
        check("wrap ptr", {8'h00, d[7:0]}, halt ? 16'h00fc : 16'h00c2);
        check("wrap out", {8'h00, pattern_out}, halt ? 16'h0077 : 16'h00a5);
    endtask

    task automatic test_resistors();
        wr(ADDR_CONFIG, 16'h0010);
        mx.pattern_reset();
        mx.strobe(1, 1'b0);
        mx.strobe(2, 1'b0);
        #1 check("map msb", {6'h00, count0}, 16'h0168);
        check("path off", {6'h00, count1}, 16'h0200);
        // Both paths are now enabled so counting and the setting write meet a driven path
        wr(ADDR_CONFIG, 16'h0038);
        mx.strobe(2, 1'b0);
        #1 check("map lsb", {6'h00, count1}, 16'h005a);
        mx.strobe(3, 1'b1);
        #1 check("count up", {6'h00, count0}, 16'h0169);
        repeat (2) mx.strobe(3, 1'b0);
        #1 check("count down", {6'h00, count0}, 16'h0167);
        wr(ADDR_RES0_SET, 16'h0155);
        #1 check("before stop", {6'h00, count0}, 16'h0167);
        repeat (2) @(posedge clock);
        i2c_stop <= 1'b1;
        @(posedge clock);
        i2c_stop <= 1'b0;
        @(posedge clock);
        #1 check("after stop", {6'h00, count0}, 16'h0155);
        rd(8'hfd);
        check("unmapped", d, 16'h0000);
    endtask

    task automatic complete_run();
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Guard against a hang
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        complete_run();
    end

    // Main sequence: reset for 20 cycles, then each scenario
    initial begin
        miscompares = 0;
        tests_run   = 0;
        reset       = 1'b1;
        i2c_stop    = 1'b0;
        reg_write   = 1'b0;
        reg_read    = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 16'h0000;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        test_reset_values();
        test_initial_value();
        test_modes();
        test_wrap(1'b0);
        test_wrap(1'b1);
        test_resistors();
        complete_run();
    end
endmodule // tb
